// ---- rtl/tcdma_pkg.sv ----
package tcdma_pkg;

	// Register word offsets (byte addresses)
	localparam logic [4:0] TCDMA_SRC0_OFS   = 5'h00;
	localparam logic [4:0] TCDMA_DST0_OFS   = 5'h04;
	localparam logic [4:0] TCDMA_CNT0_OFS   = 5'h08;
	localparam logic [4:0] TCDMA_SRC1_OFS   = 5'h0C;
	localparam logic [4:0] TCDMA_DST1_OFS   = 5'h10;
	localparam logic [4:0] TCDMA_CNT1_OFS   = 5'h14;
	localparam logic [4:0] TCDMA_CTRL_OFS   = 5'h18;
	localparam logic [4:0] TCDMA_STAT_OFS   = 5'h1C;

	// Control register fields
	localparam int TCDMA_EN0_BIT   = 0;
	localparam int TCDMA_EN1_BIT   = 1;
	localparam int TCDMA_WG0_BIT   = 2;
	localparam int TCDMA_WG1_BIT   = 3;
	localparam int TCDMA_MASTER_BIT = 4;
	localparam int TCDMA_MODE0_LO  = 8;
	localparam int TCDMA_BURST_BIT = 10;
	localparam int TCDMA_EDGE0_BIT = 11;
	localparam int TCDMA_EDGE1_BIT = 12;
	localparam int TCDMA_MODE1_BIT = 13;

	localparam logic [31:0] TCDMA_CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] TCDMA_CNT_ONE  = 16'h0001;
	localparam logic [15:0] TCDMA_CNT_ZERO = 16'h0000;
	localparam logic [1:0]  TCDMA_CH0_REQ_SEL = 2'h0;

	// Channel 0 transfer modes
	typedef enum logic [1:0] {
		TCDMA_M2M,
		TCDMA_M2IO,
		TCDMA_IO2M
	} tcdma_mode_e;

	// External bus request bundle
	typedef struct packed {
		logic [19:0] addr;
		logic [7:0]  wdata;
		logic        rd;
		logic        wr;
		logic        io;
	} tcdma_bus_s;

	typedef enum {
		TCDMA_IDLE,
		TCDMA_READ,
		TCDMA_WRITE
	} tcdma_state_e;

endpackage

// ---- rtl/tcdma_top.sv ----
// Behaviour
// - Missed receive register keeps request pending
// - Level request sampled, starts another cycle
// - Edge request option, one cycle per edge
// - Channel 0 outranks channel 1
// - Memory-to-IO channel 0 yields when idle
// - Memory-to-memory channel 0 blocks channel 1
// - IO cycle drives address and enable strobe
// - Zero byte count moves 65536 bytes
// - Enable write needs gate bit zero
// - Nonmaskable interrupt clears master at once unless an enable write sets it that cycle, running cycle completes
// - Setting channel enable sets master enable
// - Burst memory-to-memory runs uninterrupted
module tcdma_top
	import tcdma_pkg::*;
(
	// System
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	// Wishbone slave
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [4:0]  ADR_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic [31:0] DAT_I,
	output logic      [31:0] DAT_O,
	output logic             ACK_O,
	// Peripheral requests and interrupt
	input  wire logic [1:0]  TRANSFER_REQUEST_IN_I,
	input  wire logic        NMI_I,
	// Shared bus master
	input  wire logic        BUS_READY_I,
	input  wire logic [7:0]  BUS_RDATA_I,
	output logic      [19:0] BUS_ADDR_O,
	output logic      [7:0]  BUS_WDATA_O,
	output logic             BUS_RD_O,
	output logic             BUS_WR_O,
	output logic             IO_ENABLE_STROBE_O,
	output logic             BUS_GRANT_O
);

	// Pin synchronisers
	logic [1:0]  req_s1_q, req_s2_q, req_s3_q;
	logic        nmi_s1_q, nmi_s2_q, nmi_s3_q;
	logic        rdy_s1_q, rdy_s2_q;
	logic [7:0]  rd_s1_q, rd_s2_q;

	// Registers
	logic [19:0] src_q [2];
	logic [19:0] dst_q [2];
	logic [15:0] cnt_q [2];
	logic        en_q [2];
	logic        master_q;
	logic [1:0]  mode0_q;
	logic        burst_q, edge0_q, edge1_q, mode1_q;
	logic [1:0]  pend_q;
	logic        ch_q, done_q;
	logic [7:0]  data_q;
	tcdma_state_e state_q;
	tcdma_bus_s  bus_q;
	logic        ack_q;
	logic [31:0] dat_q;
	logic        rdy_arm_q;

	function automatic logic [19:0] step(input logic [19:0] a);
		step = a + 20'h0_0001;
	endfunction

	// Offset match, used by write decode only
	function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
		hit = a == o;
	endfunction

	wire wb_req   = CYC_I && STB_I && !ack_q;
	wire wb_wr    = wb_req && WE_I && SEL_I[0];
	wire wr_src0  = wb_wr && hit(ADR_I, TCDMA_SRC0_OFS);
	wire wr_dst0  = wb_wr && hit(ADR_I, TCDMA_DST0_OFS);
	wire wr_cnt0  = wb_wr && hit(ADR_I, TCDMA_CNT0_OFS);
	wire wr_src1  = wb_wr && hit(ADR_I, TCDMA_SRC1_OFS);
	wire wr_dst1  = wb_wr && hit(ADR_I, TCDMA_DST1_OFS);
	wire wr_cnt1  = wb_wr && hit(ADR_I, TCDMA_CNT1_OFS);
	wire wr_ctrl  = wb_wr && hit(ADR_I, TCDMA_CTRL_OFS);

	wire set_en0 = wr_ctrl && !DAT_I[TCDMA_WG0_BIT];
	wire set_en1 = wr_ctrl && !DAT_I[TCDMA_WG1_BIT];
	wire nmi_rise = nmi_s2_q && !nmi_s3_q;

	wire [1:0] req_edge = req_s2_q & ~req_s3_q;
	wire req0 = edge0_q ? pend_q[0] : req_s2_q[0];
	wire req1 = edge1_q ? pend_q[1] : req_s2_q[1];
	wire m2m0 = mode0_q == TCDMA_M2M;
	wire go0  = en_q[0] && (m2m0 || req0);
	// memory copy on channel 0 blocks channel 1
	wire go1  = en_q[1] && req1 && !go0 && !(en_q[0] && m2m0);
	wire [19:0] cur_src = src_q[ch_q];
	wire [19:0] cur_dst = dst_q[ch_q];
	wire cur_io_src = ch_q ? mode1_q : mode0_q == TCDMA_IO2M;
	wire cur_io_dst = ch_q ? !mode1_q : mode0_q == TCDMA_M2IO;
	// last byte when count reaches one
	wire last = cnt_q[ch_q] == TCDMA_CNT_ONE;

	// ready counts only once re-armed
	// Synced ready lags two cycles, so the ready of the
	// phase just ended would otherwise end the next one
	// at once; it must be seen low before it counts again
	wire rdy_ok = rdy_s2_q && rdy_arm_q;

	wire [31:0] ctrl_rd = {18'h0_0000, mode1_q, edge1_q, edge0_q,
		burst_q, mode0_q, 3'h0, master_q, 2'h0, en_q[1], en_q[0]};
	wire [31:0] rd_mux =
		ADR_I == TCDMA_SRC0_OFS ? {12'h000, src_q[0]} :
		ADR_I == TCDMA_DST0_OFS ? {12'h000, dst_q[0]} :
		ADR_I == TCDMA_CNT0_OFS ? {16'h0000, cnt_q[0]} :
		ADR_I == TCDMA_SRC1_OFS ? {12'h000, src_q[1]} :
		ADR_I == TCDMA_DST1_OFS ? {12'h000, dst_q[1]} :
		ADR_I == TCDMA_CNT1_OFS ? {16'h0000, cnt_q[1]} :
		ADR_I == TCDMA_CTRL_OFS ? ctrl_rd :
		ADR_I == TCDMA_STAT_OFS ? {29'h0000_0000, done_q,
			state_q != TCDMA_IDLE, ch_q} : 32'h0000_0000;

	// Pins are asynchronous; third stage only feeds edge detect
	// Costs two cycles of latency on every request and ready
	always_ff @(posedge CLK_I) begin
		req_s1_q <= TRANSFER_REQUEST_IN_I;
		req_s2_q <= req_s1_q;
		req_s3_q <= req_s2_q;
		nmi_s1_q <= NMI_I;
		nmi_s2_q <= nmi_s1_q;
		nmi_s3_q <= nmi_s2_q;
		rdy_s1_q <= BUS_READY_I;
		rdy_s2_q <= rdy_s1_q;
		rd_s1_q  <= BUS_RDATA_I;
		rd_s2_q  <= rd_s1_q;
	end

	// Ack one cycle after take, never two in a row
	// Read data stands only with ack
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= wb_req;
			dat_q <= wb_req ? rd_mux : 32'h0000_0000;
		end
	end

	assign ACK_O = ack_q;
	assign DAT_O = dat_q;
	assign BUS_ADDR_O = bus_q.addr;
	assign BUS_WDATA_O = bus_q.wdata;
	assign BUS_RD_O = bus_q.rd;
	assign BUS_WR_O = bus_q.wr;
	assign IO_ENABLE_STROBE_O = bus_q.io;

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			for (int i = 0; i < 2; i++) begin
				src_q[i] <= 20'h0_0000;
				dst_q[i] <= 20'h0_0000;
				cnt_q[i] <= TCDMA_CNT_ZERO;
				en_q[i]  <= 1'b0;
			end
			master_q <= 1'b0;
			mode0_q  <= 2'h0;
			burst_q  <= 1'b0;
			edge0_q  <= 1'b0;
			edge1_q  <= 1'b0;
			mode1_q  <= 1'b0;
			pend_q   <= 2'h0;
			ch_q     <= 1'b0;
			done_q   <= 1'b0;
			data_q   <= 8'h00;
			state_q  <= TCDMA_IDLE;
			bus_q    <= '0;
			rdy_arm_q <= 1'b0;
			BUS_GRANT_O <= 1'b0;
		end else begin
			// Re-arm once the old ready has drained
			if (!rdy_s2_q)
				rdy_arm_q <= 1'b1;
			// Edge latch; set wins over the consuming clear
			if (state_q == TCDMA_WRITE && rdy_ok)
				pend_q[ch_q] <= 1'b0;
			for (int i = 0; i < 2; i++) begin
				if (req_edge[i])
					pend_q[i] <= 1'b1;
			end
			if (wr_src0) src_q[0] <= DAT_I[19:0];
			if (wr_dst0) dst_q[0] <= DAT_I[19:0];
			if (wr_cnt0) cnt_q[0] <= DAT_I[15:0];
			if (wr_src1) src_q[1] <= DAT_I[19:0];
			if (wr_dst1) dst_q[1] <= DAT_I[19:0];
			if (wr_cnt1) cnt_q[1] <= DAT_I[15:0];
			if (wr_ctrl) begin
				mode0_q <= DAT_I[TCDMA_MODE0_LO+:2];
				burst_q <= DAT_I[TCDMA_BURST_BIT];
				edge0_q <= DAT_I[TCDMA_EDGE0_BIT];
				edge1_q <= DAT_I[TCDMA_EDGE1_BIT];
				mode1_q <= DAT_I[TCDMA_MODE1_BIT];
				done_q  <= 1'b0;
			end
			if (set_en0) en_q[0] <= DAT_I[TCDMA_EN0_BIT];
			if (set_en1) en_q[1] <= DAT_I[TCDMA_EN1_BIT];
			if ((set_en0 && DAT_I[TCDMA_EN0_BIT]) ||
			    (set_en1 && DAT_I[TCDMA_EN1_BIT]))
				master_q <= 1'b1;
			else if (nmi_rise)
				master_q <= 1'b0;
			case (state_q)
				TCDMA_IDLE: begin
					if (master_q && !nmi_rise && (go0 || go1)) begin
						ch_q <= go1;
						BUS_GRANT_O <= 1'b1;
						state_q <= TCDMA_READ;
						bus_q.addr <= go1 ? src_q[1] : src_q[0];
						bus_q.rd <= 1'b1;
						bus_q.wr <= 1'b0;
						bus_q.io <= go1 ? mode1_q :
							mode0_q == TCDMA_IO2M;
					end else begin
						BUS_GRANT_O <= 1'b0;
					end
				end
				TCDMA_READ: begin
					if (rdy_ok) begin
						rdy_arm_q <= 1'b0;
						data_q <= rd_s2_q;
						bus_q.addr <= cur_dst;
						bus_q.wdata <= rd_s2_q;
						bus_q.rd <= 1'b0;
						bus_q.wr <= 1'b1;
						bus_q.io <= cur_io_dst;
						state_q <= TCDMA_WRITE;
					end
				end
				TCDMA_WRITE: begin
					if (rdy_ok) begin
						rdy_arm_q <= 1'b0;
						bus_q <= '0;
						if (!cur_io_src)
							src_q[ch_q] <= step(cur_src);
						if (!cur_io_dst)
							dst_q[ch_q] <= step(cur_dst);
						cnt_q[ch_q] <= cnt_q[ch_q] - TCDMA_CNT_ONE;
						if (last) begin
							en_q[ch_q] <= 1'b0;
							done_q <= 1'b1;
						end
						if (!last && !ch_q && m2m0 && burst_q &&
						    master_q && !nmi_rise) begin
							state_q <= TCDMA_READ;
							bus_q.addr <= step(cur_src);
							bus_q.rd <= 1'b1;
						end else begin
							state_q <= TCDMA_IDLE;
						end
					end
				end
				default: state_q <= TCDMA_IDLE;
			endcase
		end
	end

	// serial request clears only by target access (outside)
	// Limitation: a wrong I/O address leaves that request pending,
	// so a level channel keeps moving bytes until its count ends
	wire unused = ^data_q;

endmodule

// ---- sim/tcdma_top_props.sv ----
module tcdma_top_props (
	input wire logic        CLK_I,
	input wire logic        RST_I,
	input wire logic        CYC_I,
	input wire logic        STB_I,
	input wire logic        ACK_O,
	input wire logic        NMI_I,
	input wire logic        BUS_READY_I,
	input wire logic [19:0] BUS_ADDR_O,
	input wire logic        BUS_RD_O,
	input wire logic        BUS_WR_O,
	input wire logic        IO_ENABLE_STROBE_O,
	input wire logic        BUS_GRANT_O
);
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (RST_I);
	chk_ack_answer: assert property
		(CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("no ack");
	chk_ack_pulse: assert property
		(ACK_O |=> !ACK_O) else $error("long ack");
	chk_rd_wr_excl: assert property
		(!(BUS_RD_O && BUS_WR_O)) else $error("rd with wr");
	chk_wr_after_rd: assert property
		($rose(BUS_WR_O) |-> $past(BUS_RD_O)) else $error("wr first");
	chk_rd_holds: assert property
		((BUS_RD_O && !BUS_READY_I) [*3] |=> BUS_RD_O) else $error("rd short");
	chk_addr_hold: assert property
		(BUS_RD_O && $past(BUS_RD_O) |-> $stable(BUS_ADDR_O))
		else $error("addr moved");
	chk_io_granted: assert property
		(IO_ENABLE_STROBE_O |-> BUS_GRANT_O) else $error("io no grant");
	chk_idle_quiet: assert property
		(!BUS_GRANT_O |-> !BUS_RD_O && !BUS_WR_O) else $error("idle cycle");
	chk_nmi_release: assert property
		($rose(NMI_I) |-> ##[1:60] !BUS_GRANT_O) else $error("bus kept");
	cov_ack: cover property (ACK_O);
	cov_io_wr: cover property (IO_ENABLE_STROBE_O && BUS_WR_O);
	cov_nmi: cover property ($rose(NMI_I));
endmodule

bind tcdma_top tcdma_top_props u_props (.*);

// ---- sim/tcdma_mem_model.sv ----
module tcdma_mem_model (
	input wire logic        clk_i,
	input wire logic        rd_i,
	input wire logic        wr_i,
	input wire logic        io_i,
	input wire logic [19:0] addr_i,
	input wire logic [7:0]  wdata_i,
	input wire logic [3:0]  wait_i,
	output logic            ready_o = 1'b0,
	output logic [7:0]      rdata_o,
	output int              n_wr_o = 0,
	output int              n_io_o = 0,
	output int              n_bad_o = 0
);
	logic [1:0] op_q = 2'h0;
	logic [3:0] cnt_q = 4'h0;
	logic [7:0] last_q = 8'h00;
	wire        same_w = (op_q == {rd_i, wr_i});
	// Released data lines show no stale byte
	assign rdata_o = rd_i ? (addr_i[7:0] ^ 8'h5A) : ~last_q;
	always_ff @(posedge clk_i) begin
		op_q <= {rd_i, wr_i};
		cnt_q <= same_w ? cnt_q + 4'h1 : 4'h0;
		ready_o <= same_w && (rd_i || wr_i) && cnt_q >= wait_i;
		if (rd_i) begin
			last_q <= rdata_o;
		end
		// decoded ack, byte equals byte read
		if (wr_i && !op_q[0]) begin
			n_wr_o <= n_wr_o + 1;
			n_io_o <= n_io_o + int'(io_i);
			n_bad_o <= n_bad_o + int'(wdata_i != last_q);
		end
	end
endmodule

// ---- sim/two_channel_dma_control_test.sv ----
module two_channel_dma_control_test
	import tcdma_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, nmi = 0;
	logic [4:0]  adr = 5'h00;
	logic [3:0]  wt = 4'h0;
	logic [1:0]  req = 2'h0;
	logic [31:0] dw = 32'h0000_0000, dr, rnd = 32'h0001_413A;
	logic [19:0] baddr;
	logic [7:0]  rdat, wdat;
	logic        ack, rdy, brd, bwr, io, gnt;
	int          err_total = 0, n_tests = 0, nwr, nio, nbad;
	int          exp_q[8];
	always #25 clk = ~clk;

	tcdma_top u_dut (.CLK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(stb),
		.WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dw), .DAT_O(dr),
		.ACK_O(ack), .TRANSFER_REQUEST_IN_I(req), .NMI_I(nmi),
		.BUS_READY_I(rdy), .BUS_RDATA_I(rdat), .BUS_ADDR_O(baddr),
		.BUS_WDATA_O(wdat), .BUS_RD_O(brd), .BUS_WR_O(bwr),
		.IO_ENABLE_STROBE_O(io), .BUS_GRANT_O(gnt));
	tcdma_mem_model u_mem (.clk_i(clk), .rd_i(brd), .wr_i(bwr), .io_i(io),
		.addr_i(baddr), .wdata_i(wdat), .wait_i(wt), .ready_o(rdy),
		.rdata_o(rdat), .n_wr_o(nwr), .n_io_o(nio), .n_bad_o(nbad));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wb(input logic w, input logic [4:0] a,
			input logic [31:0] d, output logic [31:0] q);
		int t;
		t = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dw <= d;
		do @(posedge clk); while (ack !== 1'b1 && ++t < 20);
		if (ack !== 1'b1)
			err_total++;
		q = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic put(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		exp_q[a[4:2]] = d;
		wb(1'b1, a, d, q);
	endtask
	task automatic get(input logic [4:0] a, input logic [31:0] m,
			input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0000_0000, q);
		chk(q & m, e);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Extra cycles let any surplus transfer show up
	task automatic wait_wr(input int n);
		int t;
		t = 0;
		while (nwr < n && t < 3000) begin
			@(posedge clk);
			t++;
		end
		idle(40);
		chk(nwr, n);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		idle(20000);
		err_total++;
		wrap_up();
	end
	initial begin
		idle(4);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			get(5'(i * 4), 32'hFFFF_FFFF, 32'h0000_0000);
		end
		rnd = lfsr(rnd);
		put(TCDMA_SRC0_OFS, rnd & 32'h000F_FFFF);
		get(TCDMA_SRC0_OFS, 32'h000F_FFFF, exp_q[0]);
		put(TCDMA_CNT0_OFS, 32'h0000_0004);
		put(TCDMA_CTRL_OFS, 32'h0000_0405);
		get(TCDMA_CTRL_OFS, 32'h0000_0011, 32'h0000_0000);
		put(TCDMA_CTRL_OFS, 32'h0000_0401);
		get(TCDMA_CTRL_OFS, 32'h0000_0011, 32'h0000_0011);
		wait_wr(4);
		chk(nbad, 0);
		get(TCDMA_CTRL_OFS, 32'h0000_0001, 32'h0000_0000);
		wt <= 4'h3;
		put(TCDMA_SRC1_OFS, rnd & 32'h000F_FFFF);
		put(TCDMA_DST1_OFS, 32'h0000_0040);
		put(TCDMA_CNT1_OFS, 32'h0000_0003);
		put(TCDMA_CTRL_OFS, 32'h0000_1002);
		req <= 2'h2;
		wait_wr(5);
		chk(nio, 1);
		put(TCDMA_CTRL_OFS, 32'h0000_0002);
		wait_wr(7);
		chk(nio, 3);
		req <= 2'h0;
		wt <= 4'h0;
		put(TCDMA_CNT0_OFS, 32'h0000_0000);
		put(TCDMA_CTRL_OFS, 32'h0000_0001);
		idle(400);
		get(TCDMA_CTRL_OFS, 32'h0000_0011, 32'h0000_0011);
		nmi <= 1'b1;
		idle(100);
		get(TCDMA_CTRL_OFS, 32'h0000_0010, 32'h0000_0000);
		chk(32'(gnt), 32'h0000_0000);
		wrap_up();
	end
endmodule
